// [tpw_top.sv]
// tpw_top: three-phase center-based pwm timing unit with apb registers
// assumes an apb master on pclk; outputs feed an output control unit
//
// Function
// - all six pair outputs are active low: low means switch on
// - one pclk cycle is the tick for every count
// - half-period register holds ticks per half period; full period is twice
// - half-period accepts every value up to all ones
// - one 10-bit dead-time register serves all three pairs
// - off-to-on gap within a pair is twice the dead-time value
// - dead time ranges zero to 0x3FF; zero inserts none
// - mode bit 6 selects double update; reset clears it
// - single mode: one sync per period; its rise latches all config except mode and interrupt mask
// - segment control is latched on the same sync rise
// - double mode adds a midpoint sync that latches everything again
// - status bit 3 clear in first half, set in second half
// - sync pulse leaves on a pin at period or twice period rate
// - sync width is register value plus one ticks
// - sync width register resets to 0x27
// - three 16-bit duty registers steer their pairs
// - duty sets high-side on-time per half; edges shift by dead time
// - no outputs until half-period and all duties written once
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/10ps
module tpw_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic phase_a_high_out,
   output logic phase_a_low_out,
   output logic phase_b_high_out,
   output logic phase_b_low_out,
   output logic phase_c_high_out,
   output logic phase_c_low_out,
   output logic period_sync_pulse,
   output logic [8:0] segment_latched,
   output logic [15:0] min_pulse_latched,
   output logic irq
);
   import tpw_pkg::*;

   // software-side shadow registers
   logic [15:0] half_period_count_ff;
   logic [9:0] dead_time_count_ff;
   logic [15:0] min_pulse_count_ff;
   logic [7:0] sync_width_count_ff;
   logic [15:0] duty_ff [3];
   logic [8:0] output_segment_control_ff;
   logic [7:0] mode_control_reg_ff;
   logic [3:0] written_ff;
   logic [TPW_IRQ_W-1:0] irq_stat_ff;
   logic [TPW_IRQ_W-1:0] irq_mask_ff;
   // timing-side latched values
   logic [15:0] lat_period_ff;
   logic [7:0] lat_sync_ff;
   logic [15:0] lat_duty_ff [3];
   logic [15:0] cnt_ff;
   tpw_phase_t phase_ff;
   logic half_ff;
   logic [8:0] sync_cnt_ff;
   logic [31:0] prdata_ff;
   tpw_cfg_if cfg ();

   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic all_written;
   logic start_evt;
   logic mid_evt;
   logic latch_evt;
   logic [31:0] rd_val;

   // one-word decode shared by read and write paths
   function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
      is_reg = (a == ofs);
   endfunction

   // zero-wait apb slave; unmapped addresses answer with pslverr
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign addr_ok = (paddr <= TPW_OFS_IRQ_MASK) && (paddr[1:0] == 2'b00);
   assign pslverr = psel && penable && !addr_ok;
   assign prdata = prdata_ff;
   assign all_written = &written_ff;

   // software writes to configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         half_period_count_ff <= TPW_HALF_PERIOD_RST;
         dead_time_count_ff <= TPW_DEAD_TIME_RST;
         min_pulse_count_ff <= TPW_DUTY_RST;
         sync_width_count_ff <= TPW_SYNC_WIDTH_RST;
         output_segment_control_ff <= TPW_SEGMENT_RST;
         mode_control_reg_ff <= 8'h00;
         irq_mask_ff <= '0;
      end
      else if (wr_en)
      begin
         if (is_reg(paddr, TPW_OFS_HALF_PERIOD))
         begin
            half_period_count_ff <= pwdata[15:0];
         end
         else if (is_reg(paddr, TPW_OFS_DEAD_TIME))
         begin
            dead_time_count_ff <= pwdata[9:0];
         end
         else if (is_reg(paddr, TPW_OFS_MIN_PULSE))
         begin
            min_pulse_count_ff <= pwdata[15:0];
         end
         else if (is_reg(paddr, TPW_OFS_SYNC_WIDTH))
         begin
            sync_width_count_ff <= pwdata[7:0];
         end
         else if (is_reg(paddr, TPW_OFS_SEGMENT))
         begin
            output_segment_control_ff <= pwdata[8:0];
         end
         else if (is_reg(paddr, TPW_OFS_MODE))
         begin
            mode_control_reg_ff <= pwdata[7:0];
         end
         else if (is_reg(paddr, TPW_OFS_IRQ_MASK))
         begin
            irq_mask_ff <= pwdata[TPW_IRQ_W-1:0];
         end
      end
   end

   // duty registers and first-write tracking, one per phase
   for (genvar g = 0; g < 3; g++)
   begin : g_duty
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            duty_ff[g] <= TPW_DUTY_RST;
            written_ff[g+1] <= 1'b0;
         end
         else if (wr_en && is_reg(paddr, TPW_OFS_DUTY_A + 12'(4 * g)))
         begin
            duty_ff[g] <= pwdata[15:0];
            written_ff[g+1] <= 1'b1;
         end
      end
   end

   // half-period write recorded; the main timer starts only once it and all three duties are written
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         written_ff[0] <= 1'b0;
      end
      else if (wr_en && is_reg(paddr, TPW_OFS_HALF_PERIOD))
      begin
         written_ff[0] <= 1'b1;
      end
   end

   // up/down period counter: one tick per pclk
   // turnaround values are each held for two ticks so a full period is exactly twice the count
   assign start_evt = (phase_ff == TPW_IDLE && all_written) ||
      (phase_ff == TPW_DOWN && cnt_ff == 16'h0000);
   assign mid_evt = (phase_ff == TPW_UP) && (cnt_ff >= lat_period_ff - 16'h0001);
   assign latch_evt = start_evt || (mid_evt && mode_control_reg_ff[TPW_MODE_DOUBLE_BIT]);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_ff <= TPW_IDLE;
         cnt_ff <= 16'h0000;
      end
      else
      begin
         case (phase_ff)
            TPW_IDLE:
            begin
               if (all_written)
               begin
                  phase_ff <= TPW_UP;
               end
               cnt_ff <= 16'h0000;
            end
            TPW_UP:
            begin
               if (mid_evt)
               begin
                  phase_ff <= TPW_DOWN;
               end
               else
               begin
                  cnt_ff <= cnt_ff + 16'h0001;
               end
            end
            TPW_DOWN:
            begin
               if (start_evt)
               begin
                  phase_ff <= TPW_UP;
                  cnt_ff <= 16'h0000;
               end
               else
               begin
                  cnt_ff <= cnt_ff - 16'h0001;
               end
            end
            default:
            begin
               phase_ff <= TPW_IDLE;
               cnt_ff <= 16'h0000;
            end
         endcase
      end
   end

   // latch shadows into the timing unit at each update point
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lat_period_ff <= TPW_HALF_PERIOD_RST;
         lat_sync_ff <= TPW_SYNC_WIDTH_RST;
         cfg.dead <= TPW_DEAD_TIME_RST;
         min_pulse_latched <= TPW_DUTY_RST;
         segment_latched <= TPW_SEGMENT_RST;
         for (int i = 0; i < 3; i++)
         begin
            lat_duty_ff[i] <= TPW_DUTY_RST;
         end
      end
      else if (latch_evt)
      begin
         lat_period_ff <= half_period_count_ff;
         lat_sync_ff <= sync_width_count_ff;
         cfg.dead <= dead_time_count_ff;
         min_pulse_latched <= min_pulse_count_ff;
         segment_latched <= output_segment_control_ff;
         for (int i = 0; i < 3; i++)
         begin
            lat_duty_ff[i] <= duty_ff[i];
         end
      end
   end

   // sync pulse: width is shadow register value plus one ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_cnt_ff <= 9'h000;
         period_sync_pulse <= 1'b0;
      end
      else if (latch_evt)
      begin
         sync_cnt_ff <= {1'b0, sync_width_count_ff};
         period_sync_pulse <= 1'b1;
      end
      else if (sync_cnt_ff != 9'h000)
      begin
         sync_cnt_ff <= sync_cnt_ff - 9'h001;
      end
      else
      begin
         period_sync_pulse <= 1'b0;
      end
   end

   // half-cycle flag flips at the midpoint even in single mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         half_ff <= 1'b0;
      end
      else if (start_evt)
      begin
         half_ff <= 1'b0;
      end
      else if (mid_evt)
      begin
         half_ff <= 1'b1;
      end
   end

   // sticky interrupt status; set wins over read-clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_stat_ff <= '0;
      end
      else
      begin
         for (int i = 0; i < TPW_IRQ_W; i++)
         begin
            if ((i == TPW_IRQ_SYNC && latch_evt) || (i == TPW_IRQ_MID && mid_evt))
            begin
               irq_stat_ff[i] <= 1'b1;
            end
            else if (rd_en && is_reg(paddr, TPW_OFS_IRQ_STAT))
            begin
               irq_stat_ff[i] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(irq_stat_ff & irq_mask_ff);

   // read mux
   always_comb
   begin
      rd_val = 32'h00000000;
      if (is_reg(paddr, TPW_OFS_HALF_PERIOD)) rd_val = {16'h0000, half_period_count_ff};
      else if (is_reg(paddr, TPW_OFS_DEAD_TIME)) rd_val = {22'h000000, dead_time_count_ff};
      else if (is_reg(paddr, TPW_OFS_MIN_PULSE)) rd_val = {16'h0000, min_pulse_count_ff};
      else if (is_reg(paddr, TPW_OFS_SYNC_WIDTH)) rd_val = {24'h000000, sync_width_count_ff};
      else if (is_reg(paddr, TPW_OFS_DUTY_A)) rd_val = {16'h0000, duty_ff[0]};
      else if (is_reg(paddr, TPW_OFS_DUTY_B)) rd_val = {16'h0000, duty_ff[1]};
      else if (is_reg(paddr, TPW_OFS_DUTY_C)) rd_val = {16'h0000, duty_ff[2]};
      else if (is_reg(paddr, TPW_OFS_SEGMENT)) rd_val = {23'h000000, output_segment_control_ff};
      else if (is_reg(paddr, TPW_OFS_MODE)) rd_val = {24'h000000, mode_control_reg_ff};
      else if (is_reg(paddr, TPW_OFS_STATUS))
      begin
         rd_val[TPW_STAT_HALF_BIT] = half_ff;
         rd_val[TPW_STAT_RUN_BIT] = (phase_ff != TPW_IDLE);
      end
      else if (is_reg(paddr, TPW_OFS_IRQ_STAT)) rd_val = {30'h00000000, irq_stat_ff};
      else if (is_reg(paddr, TPW_OFS_IRQ_MASK)) rd_val = {30'h00000000, irq_mask_ff};
   end

   // read data registered during setup so it is valid in the access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h00000000;
      end
      else if (psel && !penable && !pwrite)
      begin
         prdata_ff <= rd_val;
      end
   end

   assign cfg.count = cnt_ff;
   assign cfg.run = (phase_ff != TPW_IDLE);

   tpw_chan u_chan_a (.pclk(pclk), .presetn(presetn), .cfg(cfg), .duty(lat_duty_ff[0]),
      .high_n(phase_a_high_out), .low_n(phase_a_low_out));
   tpw_chan u_chan_b (.pclk(pclk), .presetn(presetn), .cfg(cfg), .duty(lat_duty_ff[1]),
      .high_n(phase_b_high_out), .low_n(phase_b_low_out));
   tpw_chan u_chan_c (.pclk(pclk), .presetn(presetn), .cfg(cfg), .duty(lat_duty_ff[2]),
      .high_n(phase_c_high_out), .low_n(phase_c_low_out));
endmodule

// [tpw_pkg.sv]
// tpw_pkg: register map, field positions, reset values and timing figures of the pwm timing unit
// assumes a 200 MHz pclk that also serves as the pwm time tick
package tpw_pkg;
   localparam int unsigned TPW_CLK_MHZ = 200;
   localparam int unsigned TPW_TICK_NS = 5;
   localparam int unsigned TPW_TICK_CYC = (TPW_TICK_NS * TPW_CLK_MHZ + 999) / 1000;
   localparam logic [11:0] TPW_OFS_HALF_PERIOD = 12'h000;
   localparam logic [11:0] TPW_OFS_DEAD_TIME = 12'h004;
   localparam logic [11:0] TPW_OFS_MIN_PULSE = 12'h008;
   localparam logic [11:0] TPW_OFS_SYNC_WIDTH = 12'h00C;
   localparam logic [11:0] TPW_OFS_DUTY_A = 12'h010;
   localparam logic [11:0] TPW_OFS_DUTY_B = 12'h014;
   localparam logic [11:0] TPW_OFS_DUTY_C = 12'h018;
   localparam logic [11:0] TPW_OFS_SEGMENT = 12'h01C;
   localparam logic [11:0] TPW_OFS_MODE = 12'h020;
   localparam logic [11:0] TPW_OFS_STATUS = 12'h024;
   localparam logic [11:0] TPW_OFS_IRQ_STAT = 12'h028;
   localparam logic [11:0] TPW_OFS_IRQ_MASK = 12'h02C;
   localparam int unsigned TPW_MODE_DOUBLE_BIT = 6;
   localparam int unsigned TPW_STAT_HALF_BIT = 3;
   localparam int unsigned TPW_STAT_RUN_BIT = 0;
   localparam logic [7:0] TPW_SYNC_WIDTH_RST = 8'h27;
   localparam logic [15:0] TPW_HALF_PERIOD_RST = 16'h0000;
   localparam logic [9:0] TPW_DEAD_TIME_RST = 10'h000;
   localparam logic [15:0] TPW_DUTY_RST = 16'h0000;
   localparam logic [8:0] TPW_SEGMENT_RST = 9'h000;
   localparam int unsigned TPW_IRQ_W = 2;
   localparam int unsigned TPW_IRQ_SYNC = 0;
   localparam int unsigned TPW_IRQ_MID = 1;
   typedef enum logic [1:0] {
      TPW_IDLE = 2'b00,
      TPW_UP = 2'b01,
      TPW_DOWN = 2'b10
   } tpw_phase_t;
endpackage

// [tpw_cfg_if.sv]
// tpw_cfg_if: live counter, run flag and latched dead time passed from the core to each phase channel
// assumes one clock domain; the core drives, channels only read
`timescale 1ns/10ps
interface tpw_cfg_if;
   logic [15:0] count;
   logic [9:0] dead;
   logic run;
   modport core (output count, output dead, output run);
   modport chan (input count, input dead, input run);
endinterface

// [tpw_chan.sv]
// tpw_chan: one complementary active-low pair with dead time around the duty instant
// assumes the shared counter runs up then down across a period
`timescale 1ns/10ps
module tpw_chan
(
   input wire logic pclk,
   input wire logic presetn,
   tpw_cfg_if.chan cfg,
   input wire logic [15:0] duty,
   output logic high_n,
   output logic low_n
);
   import tpw_pkg::*;
   logic [16:0] on_edge;
   logic [16:0] off_edge;
   logic nxt_high_n;
   logic nxt_low_n;
   // high side on while count below duty - dead; low side on while count at or above duty + dead
   always_comb
   begin
      on_edge = {1'b0, duty} - {7'h00, cfg.dead};
      off_edge = {1'b0, duty} + {7'h00, cfg.dead};
      nxt_high_n = 1'b1;
      nxt_low_n = 1'b1;
      if (cfg.run)
      begin
         nxt_high_n = !(on_edge[16] == 1'b0 && {1'b0, cfg.count} < on_edge);
         nxt_low_n = !({1'b0, cfg.count} >= off_edge);
      end
   end
   // outputs registered; reset holds both switches off
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         high_n <= 1'b1;
         low_n <= 1'b1;
      end
      else
      begin
         high_n <= nxt_high_n;
         low_n <= nxt_low_n;
      end
   end
endmodule

// [tpw_monitor.sv]
// tpw_monitor: port-level assertions for the pwm timing unit
// assumes one pclk domain; bound onto every tpw_top instance
`timescale 1ns/10ps
module tpw_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic phase_a_high_out,
   input wire logic phase_a_low_out,
   input wire logic phase_b_high_out,
   input wire logic phase_b_low_out,
   input wire logic phase_c_high_out,
   input wire logic phase_c_low_out,
   input wire logic period_sync_pulse,
   input wire logic [8:0] segment_latched,
   input wire logic [15:0] min_pulse_latched,
   input wire logic irq
);
   logic started_ff;
   logic all_off;
   default clocking mcb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // set by the first sync; outputs must stay off until then
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         started_ff <= 1'b0;
      else if (period_sync_pulse)
         started_ff <= 1'b1;
   end
   // every switch commanded off
   assign all_off = &{phase_a_high_out, phase_a_low_out, phase_b_high_out,
      phase_b_low_out, phase_c_high_out, phase_c_low_out};
   sequence quiet_s;
      !started_ff && !period_sync_pulse;
   endsequence
   reset_idle_a: assert property ($rose(presetn)
      |-> all_off && !period_sync_pulse && !irq)
      else $error("outputs not idle after reset");
   quiet_off_a: assert property (quiet_s |-> all_off)
      else $error("output active before start");
   pair_excl_a: assert property ((phase_a_high_out || phase_a_low_out) &&
      (phase_b_high_out || phase_b_low_out) && (phase_c_high_out || phase_c_low_out))
      else $error("both switches of a pair on");
   ready_high_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   err_unaligned_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");
   err_mapped_a: assert property (psel && penable && paddr <= 12'h02C && paddr[1:0] == 2'h0
      |-> !pslverr)
      else $error("mapped access refused");
   seg_latch_a: assert property (!$rose(period_sync_pulse)
      |-> $stable(segment_latched))
      else $error("segment changed off update point");
   minp_latch_a: assert property (!$rose(period_sync_pulse)
      |-> $stable(min_pulse_latched))
      else $error("min pulse changed off update point");
endmodule
bind tpw_top tpw_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .paddr(paddr), .pready(pready), .pslverr(pslverr), .phase_a_high_out(phase_a_high_out),
   .phase_a_low_out(phase_a_low_out), .phase_b_high_out(phase_b_high_out),
   .phase_b_low_out(phase_b_low_out), .phase_c_high_out(phase_c_high_out),
   .phase_c_low_out(phase_c_low_out), .period_sync_pulse(period_sync_pulse),
   .segment_latched(segment_latched), .min_pulse_latched(min_pulse_latched), .irq(irq));

// [tpw_partner.sv]
// tpw_partner: output control unit model measuring phase a and the sync pin
// assumes active-low pair inputs; low means the switch is commanded on
`timescale 1ns/10ps
module tpw_partner
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ah_n,
   input wire logic al_n,
   input wire logic sync,
   output int per,
   output int ah_on,
   output int gap,
   output int sw,
   output int syncs
);
   logic sq_ff;
   int c_ff, a_ff, g_ff, w_ff;
   // period, on-time, sync width and both-off gap, taken at each edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sq_ff <= 1'b0;
         {c_ff, a_ff, g_ff, w_ff, per, ah_on, gap, sw, syncs} <= '0;
      end
      else
      begin
         sq_ff <= sync;
         if (sync && !sq_ff)
         begin
            per <= c_ff;
            ah_on <= a_ff;
            c_ff <= 1;
            a_ff <= int'(!ah_n);
            syncs <= syncs + 1;
         end
         else
         begin
            c_ff <= c_ff + 1;
            a_ff <= a_ff + int'(!ah_n);
         end
         w_ff <= sync ? w_ff + 1 : 0;
         if (!sync && sq_ff)
            sw <= w_ff;
         g_ff <= (ah_n && al_n) ? g_ff + 1 : 0;
         if (!(ah_n && al_n) && g_ff != 0)
            gap <= g_ff;
      end
   end
endmodule

// [testbench.sv]
// testbench: drives tpw_top over apb and judges its pwm outputs
// assumes tpw_partner stands in for the output control unit
`timescale 1ns/10ps
module testbench;
   import tpw_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic ah, al, bh, bl, ch, cl, sync, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [8:0] seg;
   logic [15:0] minp;
   int fails, checks, per, ahon, gap, sw, syncs;
   tpw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phase_a_high_out(ah), .phase_a_low_out(al), .phase_b_high_out(bh),
      .phase_b_low_out(bl), .phase_c_high_out(ch), .phase_c_low_out(cl),
      .period_sync_pulse(sync), .segment_latched(seg), .min_pulse_latched(minp), .irq(irq));
   tpw_partner ocu (.pclk(pclk), .presetn(presetn), .ah_n(ah), .al_n(al), .sync(sync),
      .per(per), .ah_on(ahon), .gap(gap), .sw(sw), .syncs(syncs));
   // free-running 200 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x)
      begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, s, x);
      end
   endtask
   // one apb transfer; request held until ready is seen, only the watchdog ends a hang
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wait_sync;
      int n, s0;
      s0 = syncs;
      n = 0;
      while (syncs == s0 && n < 3000)
      begin
         @(posedge pclk);
         n++;
      end
      chk(n < 3000, 1);
   endtask
   task t_reset;
      apb(0, TPW_OFS_SYNC_WIDTH, 0);
      chk(r, 32'h27);
      apb(0, TPW_OFS_MODE, 0);
      chk(r[6], 0);
      apb(0, 12'h040, 0);
      chk(e, 1);
      chk(r, 0);
      apb(1, TPW_OFS_HALF_PERIOD, 40);
      apb(1, TPW_OFS_DUTY_A, 20);
      repeat (100) @(posedge pclk);
      chk(sync, 0);
      chk({ah, al}, 2'b11);
      $display("done reset");
   endtask
   task t_single;
      int al_on, bh_on, bl_on, ch_on, cl_on;
      apb(1, TPW_OFS_SYNC_WIDTH, 4);
      apb(1, TPW_OFS_DEAD_TIME, 3);
      apb(1, TPW_OFS_DUTY_B, 10);
      apb(1, TPW_OFS_DUTY_C, 30);
      repeat (3) wait_sync;
      chk(sw, 5);
      chk(per, 80);
      chk(ahon, 34);
      chk(gap, 6);
      repeat (10) @(posedge pclk);
      apb(0, TPW_OFS_STATUS, 0);
      chk(r[3], 0);
      repeat (40) @(posedge pclk);
      apb(0, TPW_OFS_STATUS, 0);
      chk(r[3], 1);
      // one full period of the other outputs, sampled between edges where they are settled
      {al_on, bh_on, bl_on, ch_on, cl_on} = '0;
      repeat (80)
      begin
         @(negedge pclk);
         al_on += int'(!al);
         bh_on += int'(!bh);
         bl_on += int'(!bl);
         ch_on += int'(!ch);
         cl_on += int'(!cl);
      end
      @(posedge pclk);
      chk(al_on, 34);
      chk(bh_on, 14);
      chk(bl_on, 54);
      chk(ch_on, 54);
      chk(cl_on, 14);
      $display("done single");
   endtask
   task t_irq;
      apb(1, TPW_OFS_IRQ_MASK, 0);
      wait_sync;
      chk(irq, 0);
      apb(1, TPW_OFS_IRQ_MASK, 1);
      chk(irq, 1);
      apb(0, TPW_OFS_IRQ_STAT, 0);
      chk(r[0], 1);
      chk(irq, 0);
      $display("done irq");
   endtask
   task t_double;
      apb(1, TPW_OFS_MODE, 32'h40);
      apb(0, TPW_OFS_MODE, 0);
      chk(r, 32'h40);
      repeat (3) wait_sync;
      chk(per, 40);
      apb(1, TPW_OFS_SEGMENT, 32'h1A5);
      apb(1, TPW_OFS_MIN_PULSE, 7);
      chk(seg, 0);
      wait_sync;
      chk(seg, 9'h1A5);
      chk(minp, 16'h0007);
      $display("done double");
   endtask
   task t_limits;
      apb(1, TPW_OFS_DEAD_TIME, 32'hFFFF);
      apb(0, TPW_OFS_DEAD_TIME, 0);
      chk(r, 32'h3FF);
      apb(1, TPW_OFS_HALF_PERIOD, 32'hFFFF);
      apb(0, TPW_OFS_HALF_PERIOD, 0);
      chk(r, 32'hFFFF);
      $display("done limits");
   endtask
   task finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 5000 cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails++;
      finish_test;
   end
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_single;
      t_irq;
      t_double;
      t_limits;
      finish_test;
   end
endmodule
